// *** common/alu_exec_pkg.sv ***
// types shared by the execution datapath modules
// numbers live in the constants header
package alu_exec_pkg;

    // operation selected by the decoder
    typedef enum logic [3:0] {
        ALU_NOP        = 4'h0,
        ALU_ADD_IMM    = 4'h1,
        ALU_ADD_REG    = 4'h2,
        ALU_AND_IMM    = 4'h3,
        ALU_AND_REG    = 4'h4,
        ALU_BIT_CLR    = 4'h5,
        ALU_BIT_SET    = 4'h6,
        ALU_TEST_ZERO  = 4'h7,
        ALU_TEST_ONE   = 4'h8
    } alu_op_t;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } exec_state_t;

endpackage

// *** common/alu_exec_regs.svh ***
// constants of the execution datapath
// assumes a 14-bit instruction word and an 8-bit data path
// Function
// RULE1: literal add into accumulator, flags c dc z
// RULE2: accumulator plus file register, flags c dc z
// RULE3: destination bit 0 accumulator, 1 file
// RULE4: literal and into accumulator, zero only
// RULE5: accumulator and file register, zero only
// RULE6: bit clear in file, no flags
// RULE7: bit set in file, no flags
// RULE8: skip next instruction when tested bit zero
// RULE9: skip next instruction when tested bit one
// RULE10: taken skip costs nop cycle, flags kept
// RULE11: port read-modify-write uses synchronised pin levels
// RULE12: zero on zero result, carries bits 7/3
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH

// register offsets
`define ACC_OFFSET        8'h00
`define STATUS_OFFSET     8'h04
`define EXEC_INFO_OFFSET  8'h08

// status bits
`define STATUS_C_BIT      0
`define STATUS_DC_BIT     1
`define STATUS_Z_BIT      2

// reset values
`define ACC_RESET         8'h00
`define STATUS_RESET      3'h0

// file address of the port pins
`define PORT_ADDR         7'h06

// instruction field positions
`define INSTR_W           14
`define DEST_BIT          7
`define BIT_IDX_LSB       7
`define FILE_ADDR_MSB     6

`endif

// *** common/alu_if.sv ***
// bundle between sequencer and arithmetic unit
// assumes one clock domain; the unit is combinational
`timescale 1ns/10ps
interface alu_if;
    import alu_exec_pkg::*;
    alu_op_t    op;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [2:0] bit_idx;
    logic [7:0] result;
    logic       c;
    logic       dc;
    logic       z;
    logic       upd_c;
    logic       upd_dc;
    logic       upd_z;
    logic       skip;

    modport seq (output op, acc, opnd, bit_idx,
                 input  result, c, dc, z, upd_c, upd_dc, upd_z, skip);
    modport unit (input  op, acc, opnd, bit_idx,
                  output result, c, dc, z, upd_c, upd_dc, upd_z, skip);
endinterface

// *** rtl/alu_exec.sv ***
// byte and bit execution datapath: literal/file add and and, bit clear and set,
// bit test with skip; software sees accumulator and flags over a plain port
// assumes the data register file answers i_file_rdata combinationally
// from o_file_addr within the same cycle, and the decoder honours o_instr_ready
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "alu_exec_regs.svh"
module alu_exec
    import alu_exec_pkg::*;
#(
    parameter logic [6:0] PORT_ADDR = `PORT_ADDR
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // instruction from the decoder
    input  wire logic                 i_instr_valid,
    input  wire logic [`INSTR_W-1:0]  i_instr,
    output logic                      o_instr_ready,
    // data register file
    output logic      [6:0]           o_file_addr,
    input  wire logic [7:0]           i_file_rdata,
    output logic                      o_file_we,
    output logic      [7:0]           o_file_wdata,
    // i/o port pin levels
    input  wire logic [7:0]           i_port_pins,
    // state seen by the core
    output logic      [7:0]           o_acc,
    output logic      [2:0]           o_flags,
    output logic                      o_skip,
    output logic                      o_discard,
    // software register port
    input  wire logic [7:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [31:0]          o_rdata
);

    // decode a word into an operation; unknown words run as nop
    function automatic alu_op_t decode_op(input logic [`INSTR_W-1:0] w);
        alu_op_t op;
        op = ALU_NOP;
        casez (w)
            14'b00_0111_????_????: op = ALU_ADD_REG;
            14'b00_0101_????_????: op = ALU_AND_REG;
            14'b01_00??_????_????: op = ALU_BIT_CLR;
            14'b01_01??_????_????: op = ALU_BIT_SET;
            14'b01_10??_????_????: op = ALU_TEST_ZERO;
            14'b01_11??_????_????: op = ALU_TEST_ONE;
            14'b11_111?_????_????: op = ALU_ADD_IMM;
            14'b11_1001_????_????: op = ALU_AND_IMM;
            default:               op = ALU_NOP;
        endcase
        return op;
    endfunction

    // literal forms take the low byte and never touch the file
    function automatic logic is_literal(input alu_op_t op);
        return (op == ALU_ADD_IMM) || (op == ALU_AND_IMM);
    endfunction

    // byte-oriented file forms honour the destination bit
    function automatic logic is_byte_reg(input alu_op_t op);
        return (op == ALU_ADD_REG) || (op == ALU_AND_REG);
    endfunction

    exec_state_t state;
    exec_state_t next_state;
    alu_op_t     op;
    alu_op_t     next_op;
    logic [7:0]  literal;
    logic [7:0]  next_literal;
    logic        dest_file;
    logic        next_dest_file;
    logic [2:0]  bit_idx;
    logic [2:0]  next_bit_idx;
    logic [6:0]  file_addr;
    logic [6:0]  next_file_addr;
    logic        ready;
    logic        next_ready;
    logic        skip_pending;
    logic        next_skip_pending;
    logic        skip;
    logic        next_skip;
    logic        discard;
    logic        next_discard;
    logic        file_we;
    logic        next_file_we;
    logic [7:0]  file_wdata;
    logic [7:0]  next_file_wdata;
    logic [7:0]  acc;
    logic [7:0]  next_acc;
    logic [2:0]  flags;
    logic [2:0]  next_flags;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    logic [7:0]  pins_sync;
    logic [7:0]  file_value;
    logic        accept;

    alu_if alu ();

    // pins come from outside the clock domain
    pin_sync #(
        .WIDTH (8)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_port_pins),
        .o_q     (pins_sync)
    );

    alu_unit u_alu_unit (
        .a (alu.unit)
    );

    assign accept = i_instr_valid && ready;

    // a port register modified from itself reads the pins, not its latch
    assign file_value = (file_addr == PORT_ADDR) ? pins_sync : i_file_rdata; // [RULE11]

    // operands toward the arithmetic unit
    always_comb
    begin
        alu.op      = op;
        alu.acc     = acc;
        alu.opnd    = is_literal(op) ? literal : file_value;
        alu.bit_idx = bit_idx;
    end

    // sequencer: accept, then execute one cycle later; bus writes lose to
    // an instruction writing the same state in the same cycle
    always_comb
    begin
        next_state        = state;
        next_op           = op;
        next_literal      = literal;
        next_dest_file    = dest_file;
        next_bit_idx      = bit_idx;
        next_file_addr    = file_addr;
        next_ready        = ready;
        next_skip_pending = skip_pending;
        next_skip         = 1'b0;
        next_discard      = 1'b0;
        next_file_we      = 1'b0;
        next_file_wdata   = file_wdata;
        next_acc          = acc;
        next_flags        = flags;

        // software writes to accumulator and flags
        if (i_wr && (i_addr == `ACC_OFFSET))
        begin
            next_acc = i_wdata[7:0];
        end
        if (i_wr && (i_addr == `STATUS_OFFSET))
        begin
            next_flags = i_wdata[2:0];
        end

        unique case (state)
            ST_IDLE:
            begin
                if (accept)
                begin
                    // the word after a taken skip is dropped and runs as a nop
                    if (skip_pending)
                    begin
                        next_op           = ALU_NOP;        // [RULE8] [RULE9]
                        next_skip_pending = 1'b0;
                        next_discard      = 1'b1;           // [RULE10]
                    end
                    else
                    begin
                        next_op = decode_op(i_instr);
                    end
                    next_literal   = i_instr[7:0];
                    next_dest_file = i_instr[`DEST_BIT];
                    next_bit_idx   = i_instr[`BIT_IDX_LSB+2:`BIT_IDX_LSB];
                    next_file_addr = i_instr[`FILE_ADDR_MSB:0];
                    next_ready     = 1'b0;
                    next_state     = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                // flags change only where the operation allows it
                if (alu.upd_c)
                begin
                    next_flags[`STATUS_C_BIT] = alu.c;      // [RULE1] [RULE2] [RULE12]
                end
                if (alu.upd_dc)
                begin
                    next_flags[`STATUS_DC_BIT] = alu.dc;    // [RULE1] [RULE2] [RULE12]
                end
                if (alu.upd_z)
                begin
                    next_flags[`STATUS_Z_BIT] = alu.z;      // [RULE4] [RULE5] [RULE12]
                end

                if (is_literal(op))
                begin
                    next_acc = alu.result;                  // [RULE1] [RULE4]
                end
                else if (is_byte_reg(op))
                begin
                    if (dest_file)
                    begin
                        next_file_we    = 1'b1;             // [RULE3]
                        next_file_wdata = alu.result;
                    end
                    else
                    begin
                        next_acc = alu.result;              // [RULE3]
                    end
                end
                else if ((op == ALU_BIT_CLR) || (op == ALU_BIT_SET))
                begin
                    next_file_we    = 1'b1;                 // [RULE6] [RULE7]
                    next_file_wdata = alu.result;
                end

                // test ops touch no flag; a taken skip arms the nop slot
                if (alu.skip)
                begin
                    next_skip         = 1'b1;               // [RULE10]
                    next_skip_pending = 1'b1;               // [RULE8] [RULE9]
                end
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
            default:
            begin
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
        endcase
    end

    // read port: data only in the cycle after the strobe, zero elsewhere
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (i_rd)
        begin
            unique case (i_addr)
                `ACC_OFFSET:       next_rdata = {24'h00_0000, acc};
                `STATUS_OFFSET:    next_rdata = {29'h0000_0000, flags};
                `EXEC_INFO_OFFSET: next_rdata = {28'h000_0000, skip_pending,
                                                 ready, state};
                default:           next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // registers only
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state        <= ST_IDLE;
            op           <= ALU_NOP;
            literal      <= 8'h00;
            dest_file    <= 1'b0;
            bit_idx      <= 3'h0;
            file_addr    <= 7'h00;
            ready        <= 1'b1;
            skip_pending <= 1'b0;
            skip         <= 1'b0;
            discard      <= 1'b0;
            file_we      <= 1'b0;
            file_wdata   <= 8'h00;
            acc          <= `ACC_RESET;
            flags        <= `STATUS_RESET;
            rdata        <= 32'h0000_0000;
        end
        else
        begin
            state        <= next_state;
            op           <= next_op;
            literal      <= next_literal;
            dest_file    <= next_dest_file;
            bit_idx      <= next_bit_idx;
            file_addr    <= next_file_addr;
            ready        <= next_ready;
            skip_pending <= next_skip_pending;
            skip         <= next_skip;
            discard      <= next_discard;
            file_we      <= next_file_we;
            file_wdata   <= next_file_wdata;
            acc          <= next_acc;
            flags        <= next_flags;
            rdata        <= next_rdata;
        end
    end

    // every output is a flip-flop
    assign o_instr_ready = ready;
    assign o_file_addr   = file_addr;
    assign o_file_we     = file_we;
    assign o_file_wdata  = file_wdata;
    assign o_acc         = acc;
    assign o_flags       = flags;
    assign o_skip        = skip;
    assign o_discard     = discard;
    assign o_rdata       = rdata;

endmodule

// *** rtl/alu_unit.sv ***
// combinational arithmetic and bit unit of the execution datapath
// assumes operands are stable for the whole execute cycle
`timescale 1ns/10ps
module alu_unit
    import alu_exec_pkg::*;
(
    alu_if.unit a
);

    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] mask;

    // add and bit-mask shared by several operations
    always_comb
    begin
        sum  = {1'b0, a.acc} + {1'b0, a.opnd};
        nib  = {1'b0, a.acc[3:0]} + {1'b0, a.opnd[3:0]};
        mask = 8'h01 << a.bit_idx;
    end

    // result, flag values and which flags the operation may touch
    always_comb
    begin
        a.result = a.opnd;
        a.upd_c  = 1'b0;
        a.upd_dc = 1'b0;
        a.upd_z  = 1'b0;
        a.skip   = 1'b0;
        unique case (a.op)
            ALU_ADD_IMM, ALU_ADD_REG:
            begin
                a.result = sum[7:0];                         // [RULE1] [RULE2]
                a.upd_c  = 1'b1;
                a.upd_dc = 1'b1;
                a.upd_z  = 1'b1;
            end
            ALU_AND_IMM, ALU_AND_REG:
            begin
                a.result = a.acc & a.opnd;                   // [RULE4] [RULE5]
                a.upd_z  = 1'b1;
            end
            ALU_BIT_CLR:   a.result = a.opnd & ~mask;        // [RULE6]
            ALU_BIT_SET:   a.result = a.opnd | mask;         // [RULE7]
            ALU_TEST_ZERO: a.skip = ~|(a.opnd & mask);       // [RULE8]
            ALU_TEST_ONE:  a.skip = |(a.opnd & mask);        // [RULE9]
            ALU_NOP:       a.result = a.opnd;
            default:       a.result = a.opnd;
        endcase
    end

    // carry out of bit 7 and 3, zero on the 8-bit result
    assign a.c  = sum[8];                                    // [RULE12]
    assign a.dc = nib[4];                                    // [RULE12]
    assign a.z  = (a.result == 8'h00);                       // [RULE12]

endmodule

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for the i/o port pin levels
// assumes pins asynchronous to i_clk; only stage two reads stage one
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;

    // plain two-flop chain, nothing looks at meta
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta   <= '0;
            stable <= '0;
        end
        else
        begin
            meta   <= i_d;
            stable <= meta;
        end
    end

    assign o_q = stable;

endmodule

// *** tb/alu_exec_checker.sv ***
// concurrent checks, attached by bind
// assumes pins stay steady through the synchroniser
`timescale 1ns/10ps
`include "alu_exec_regs.svh"
module alu_exec_checker
    import alu_exec_pkg::*;
#(
    parameter logic [6:0] PORT_ADDR = `PORT_ADDR
) (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_instr_valid,
    input wire logic [13:0] i_instr,
    input wire logic        o_instr_ready,
    input wire logic [6:0]  o_file_addr,
    input wire logic [7:0]  i_file_rdata,
    input wire logic        o_file_we,
    input wire logic [7:0]  o_file_wdata,
    input wire logic [7:0]  i_port_pins,
    input wire logic [7:0]  o_acc,
    input wire logic [2:0]  o_flags,
    input wire logic        o_skip,
    input wire logic        o_discard,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata
);
    logic [13:0] ins_d1, ins_d2;
    logic [7:0]  acc_d1, rd_d1, pin_d1, opnd, andv, mask, src;
    logic [2:0]  fl_d1;
    logic [8:0]  sum;
    logic [4:0]  nib;
    logic        accept, f_port;

    // operand history, tying each result to its cause
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ins_d1 <= '0;
            ins_d2 <= '0;
            acc_d1 <= '0;
            rd_d1  <= '0;
            pin_d1 <= '0;
            fl_d1  <= '0;
        end
        else
        begin
            ins_d1 <= i_instr;
            ins_d2 <= ins_d1;
            acc_d1 <= o_acc;
            rd_d1  <= i_file_rdata;
            pin_d1 <= i_port_pins;
            fl_d1  <= o_flags;
        end
    end

    // reference results
    assign accept = i_instr_valid & o_instr_ready;
    assign f_port = i_instr[6:0] == PORT_ADDR;
    assign opnd   = ins_d2[13] ? ins_d2[7:0] : rd_d1;
    assign sum    = {1'b0, acc_d1} + {1'b0, opnd};
    assign nib    = {1'b0, acc_d1[3:0]} + {1'b0, opnd[3:0]};
    assign andv   = acc_d1 & opnd;
    assign mask   = 8'h01 << ins_d2[9:7];
    assign src    = (ins_d2[6:0] == PORT_ADDR) ? pin_d1 : rd_d1;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_add_imm;
        accept && i_instr[13:9] == 5'h1f ##1 !o_discard |=>
            o_acc == sum[7:0] && o_flags == {sum[7:0] == 8'h00, nib[4], sum[8]};
    endproperty
    a_add_imm: assert property (p_add_imm)
        else $error("literal add wrong");

    property p_add_reg;
        accept && i_instr[13:8] == 6'h07 && !f_port ##1 !o_discard |=>
            o_flags == {sum[7:0] == 8'h00, nib[4], sum[8]} && (ins_d2[7] ?
            (o_file_we && o_file_wdata == sum[7:0] && o_acc == acc_d1) :
            (!o_file_we && o_acc == sum[7:0]));
    endproperty
    a_add_reg: assert property (p_add_reg)
        else $error("file add wrong");

    property p_and_imm;
        accept && i_instr[13:8] == 6'h39 ##1 !o_discard |=>
            o_acc == andv && o_flags == {andv == 8'h00, fl_d1[1:0]};
    endproperty
    a_and_imm: assert property (p_and_imm)
        else $error("literal and wrong");

    property p_and_reg;
        accept && i_instr[13:8] == 6'h05 && !f_port ##1 !o_discard |=>
            o_flags == {andv == 8'h00, fl_d1[1:0]} && (ins_d2[7] ?
            (o_file_we && o_file_wdata == andv && o_acc == acc_d1) :
            (!o_file_we && o_acc == andv));
    endproperty
    a_and_reg: assert property (p_and_reg)
        else $error("file and wrong");

    property p_bclr;
        accept && i_instr[13:10] == 4'h4 && !f_port ##1 !o_discard |=>
            o_file_we && o_file_wdata == (rd_d1 & ~mask) && o_flags == fl_d1;
    endproperty
    a_bclr: assert property (p_bclr)
        else $error("bit clear wrong");

    property p_bset;
        accept && i_instr[13:10] == 4'h5 && !f_port ##1 !o_discard |=>
            o_file_we && o_file_wdata == (rd_d1 | mask) && o_flags == fl_d1;
    endproperty
    a_bset: assert property (p_bset)
        else $error("bit set wrong");

    property p_port;
        accept && i_instr[13:11] == 3'b010 && f_port ##1 !o_discard |=>
            o_file_we && o_file_wdata == (ins_d2[10] ? (pin_d1 | mask) : (pin_d1 & ~mask));
    endproperty
    a_port: assert property (p_port)
        else $error("port bit change ignored pins");

    property p_skip;
        accept && i_instr[13:11] == 3'b011 ##1 !o_discard |=>
            o_skip == (src[ins_d2[9:7]] == ins_d2[10]) && !o_file_we && o_flags == fl_d1;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip decision wrong");

    property p_discard;
        accept && o_skip |=> o_discard ##1
            (!o_file_we && !o_skip && o_acc == acc_d1 && o_flags == fl_d1);
    endproperty
    a_discard: assert property (p_discard)
        else $error("skipped word not dropped");
endmodule

bind alu_exec alu_exec_checker #(.PORT_ADDR(PORT_ADDR)) chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .o_instr_ready(o_instr_ready), .o_file_addr(o_file_addr), .i_file_rdata(i_file_rdata),
    .o_file_we(o_file_we), .o_file_wdata(o_file_wdata), .i_port_pins(i_port_pins),
    .o_acc(o_acc), .o_flags(o_flags), .o_skip(o_skip), .o_discard(o_discard),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));

// *** tb/file_model.sv ***
// data register file at the datapath's far side
// assumes one clock; reads answer combinationally from the address
`timescale 1ns/10ps
module file_model
(
    input  wire logic       i_clk,
    input  wire logic [6:0] i_addr,
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [128];

    // cleared so an early read feeds no unknowns
    initial
    begin
        foreach (mem[i])
            mem[i] = 8'h00;
    end

    // combinational read for the execute cycle
    assign o_rdata = mem[i_addr];

    // write lands on the strobe's edge
    always @(posedge i_clk)
    begin
        if (i_we)
            mem[i_addr] <= i_wdata;
    end
endmodule

// *** tb/test_alu_exec.sv ***
// self-checking bench for the execution datapath
// assumes a combinational file model; one 250 MHz clock
`timescale 1ns/10ps
`include "alu_exec_regs.svh"
module test_alu_exec
    import alu_exec_pkg::*;
;
    typedef struct packed {
        logic [13:0] w;
        logic [7:0]  a;
        logic [2:0]  f;
        logic [7:0]  fv;
        logic [7:0]  ea;
        logic [2:0]  ef;
        logic [7:0]  efv;
        logic        sk;
    } row_t;

    // word, acc, flags, file in -> acc, flags, file out, skip
    row_t rows [14] = '{
        '{14'h3e01, 8'hff, 3'h0, 8'h00, 8'h00, 3'h7, 8'h00, 1'b0},
        '{14'h3e08, 8'h08, 3'h0, 8'h00, 8'h10, 3'h2, 8'h00, 1'b0},
        '{14'h3eff, 8'h00, 3'h0, 8'h00, 8'hff, 3'h0, 8'h00, 1'b0},
        '{14'h0720, 8'h80, 3'h0, 8'h80, 8'h00, 3'h5, 8'h80, 1'b0},
        '{14'h07ff, 8'h0f, 3'h0, 8'h01, 8'h0f, 3'h2, 8'h10, 1'b0},
        '{14'h390f, 8'hf0, 3'h3, 8'h00, 8'h00, 3'h7, 8'h00, 1'b0},
        '{14'h05a2, 8'h3c, 3'h3, 8'h0f, 8'h3c, 3'h3, 8'h0c, 1'b0},
        '{14'h0527, 8'haa, 3'h0, 8'h55, 8'h00, 3'h4, 8'h55, 1'b0},
        '{14'h13a3, 8'h11, 3'h7, 8'hff, 8'h11, 3'h7, 8'h7f, 1'b0},
        '{14'h1424, 8'h22, 3'h0, 8'h00, 8'h22, 3'h0, 8'h01, 1'b0},
        '{14'h19a5, 8'h33, 3'h5, 8'hf7, 8'h33, 3'h5, 8'hf7, 1'b1},
        '{14'h19a5, 8'h33, 3'h2, 8'h08, 8'h33, 3'h2, 8'h08, 1'b0},
        '{14'h1f26, 8'h44, 3'h7, 8'h40, 8'h44, 3'h7, 8'h40, 1'b1},
        '{14'h1f26, 8'h44, 3'h0, 8'hbf, 8'h44, 3'h0, 8'hbf, 1'b0}};

    logic        i_clk, i_rst_n, i_instr_valid, i_wr, i_rd;
    logic [13:0] i_instr;
    logic [7:0]  i_port_pins, i_addr, file_rdata, file_wdata, o_acc;
    logic [31:0] i_wdata, o_rdata;
    logic [6:0]  file_addr;
    logic [2:0]  o_flags;
    logic        o_instr_ready, file_we, o_skip, o_discard;
    int          fail_count, num_checks, cycles;

    alu_exec dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_file_addr(file_addr),
        .i_file_rdata(file_rdata), .o_file_we(file_we), .o_file_wdata(file_wdata),
        .i_port_pins(i_port_pins), .o_acc(o_acc), .o_flags(o_flags), .o_skip(o_skip),
        .o_discard(o_discard), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata));

    file_model fm (.i_clk(i_clk), .i_addr(file_addr), .i_we(file_we),
        .i_wdata(file_wdata), .o_rdata(file_rdata));

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task check(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task bus_read(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(n, e, o_rdata);
    endtask

    // ready is looked at mid-cycle, never in the edge that updates it
    task issue(input logic [13:0] w, input logic hold);
        i_instr <= w;
        i_instr_valid <= 1'b1;
        @(negedge i_clk);
        while (o_instr_ready !== 1'b1) @(negedge i_clk);
        @(posedge i_clk);
        if (!hold)
            i_instr_valid <= 1'b0;
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // hang guard; the run needs under two hundred cycles
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    initial
    begin
        {i_rst_n, i_instr_valid, i_wr, i_rd, i_instr, i_addr, i_wdata} = '0;
        i_port_pins = 8'h5a;
        repeat (10) @(posedge i_clk);
        check("ready in reset", 32'h1, 32'(o_instr_ready));
        check("acc in reset", 32'h0, 32'(o_acc));
        i_rst_n <= 1'b1;
        for (int i = 0; i < 14; i++)
        begin
            bus_write(`ACC_OFFSET, 32'(rows[i].a));
            bus_write(`STATUS_OFFSET, 32'(rows[i].f));
            fm.mem[rows[i].w[6:0]] = rows[i].fv;
            issue(rows[i].w, 1'b0);
            @(posedge i_clk);
            #1;
            check("acc", 32'(rows[i].ea), 32'(o_acc));
            check("flags", 32'(rows[i].ef), 32'(o_flags));
            check("skip", 32'(rows[i].sk), 32'(o_skip));
            if (rows[i].sk)
            begin
                issue(14'h3e01, 1'b0);
                #1;
                check("discard", 32'h1, 32'(o_discard));
                @(posedge i_clk);
                #1;
                check("acc after drop", 32'(rows[i].ea), 32'(o_acc));
            end
            @(posedge i_clk);
            #1;
            check("file", 32'(rows[i].efv), 32'(fm.mem[rows[i].w[6:0]]));
            $display("row %0d done", i);
        end
        // port latch zero, pins differ
        fm.mem[`PORT_ADDR] = 8'h00;
        issue({7'h28, `PORT_ADDR}, 1'b0);
        repeat (2) @(posedge i_clk);
        #1;
        check("port write", 32'(8'h5a | 8'h01), 32'(fm.mem[`PORT_ADDR]));
        $display("port test done");
        // second word must wait, not vanish
        bus_write(`ACC_OFFSET, 32'h10);
        issue(14'h3e01, 1'b1);
        issue(14'h3e02, 1'b0);
        @(posedge i_clk);
        #1;
        check("acc after pair", 32'h13, 32'(o_acc));
        $display("back to back done");
        bus_write(`STATUS_OFFSET, 32'h5);
        bus_read(`STATUS_OFFSET, 32'h5, "status");
        bus_read(`ACC_OFFSET, 32'h13, "acc register");
        bus_read(`EXEC_INFO_OFFSET, 32'h4, "exec info");
        bus_read(8'h0c, 32'h0, "unmapped");
        $display("register test done");
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        #1;
        check("ready after reset", 32'h1, 32'(o_instr_ready));
        check("acc after reset", 32'h0, 32'(o_acc));
        check("flags after reset", 32'h0, 32'(o_flags));
        $display("reset test done");
        print_verdict();
    end
endmodule
